/* File: rtl/serial_eeprom.v */
// Overview of operation
// [R1] frame is 13 bits x16, 14 bits x8
// [R2] start bit, opcode, address, then write data
// [R3] serial input sampled on serial clock rise
// [R4] output released except read data or status
// [R5] after programming starts, selected output shows ready
// [R6] a one on input releases status output
// [R7] shared-line host shifts dummy one before driving
// [R8] programming needs program_enable high; lock/unlock ignore it
// [R9] read sends zero dummy bit, then msb first
// [R10] read bits change on serial clock rise
// [R11] sequential read auto-increments, wraps to zero
// [R12] only first streamed word gets dummy bit
// [R13] host holds chip select low minimum time
// [R14] chip select fall starts self-timed write
// [R15] programming completes with no serial clock
// [R16] erase sets addressed word to all ones
// [R17] program cycle finishes within 5 ms
// [R18] host waits after power-up before access
// [R19] opcode and special group encodings
// [R20] powers up locked; unlock until lock
// [R21] width_select high gives 16-bit words
// [R22] idle decoder ignores zeros until start bit
// [R23] early chip select drop abandons instruction
`include "eeprom_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom #(
    parameter PROG_CYCLES = (`PROGRAM_CYCLE_TIME_MS * (`MCLK_HZ / 1000)),
    parameter TIMER_W = 20
) (
    input wire mclk,
    input wire arst_n,
    input wire chip_select,
    input wire serial_clock,
    input wire serial_in,
    input wire width_select,
    input wire program_enable,
    output reg serial_out,
    output reg serial_out_oe,
    output reg program_busy,
    output reg write_unlocked
);

    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_CMD = 5'b00010;
    localparam [4:0] ST_DATA = 5'b00100;
    localparam [4:0] ST_READ = 5'b01000;
    localparam [4:0] ST_DONE = 5'b10000;

    localparam [1:0] JOB_WRITE = 2'd0;
    localparam [1:0] JOB_ERASE = 2'd1;
    localparam [1:0] JOB_FILL = 2'd2;
    localparam [1:0] JOB_CLEAR = 2'd3;

    // two-flop synchronisers on every pin but mclk and arst_n, third flop on clock and chip select for edges
    reg [1:0] cs_sy, sk_sy, di_sy, ws_sy, pe_sy;
    reg sk_q, cs_q;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cs_sy <= 2'b00;
            sk_sy <= 2'b00;
            di_sy <= 2'b00;
            ws_sy <= 2'b11;
            pe_sy <= 2'b11;
            sk_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            cs_sy <= {cs_sy[0], chip_select};
            sk_sy <= {sk_sy[0], serial_clock};
            di_sy <= {di_sy[0], serial_in};
            ws_sy <= {ws_sy[0], width_select};
            pe_sy <= {pe_sy[0], program_enable};
            sk_q <= sk_sy[1];
            cs_q <= cs_sy[1];
        end
    end

    wire cs = cs_sy[1];
    wire di = di_sy[1];
    wire wide = ws_sy[1]; // [R21]
    wire sk_rise = sk_sy[1] & ~sk_q;
    wire sk_fall = ~sk_sy[1] & sk_q;
    wire cs_fall = ~cs & cs_q;

    reg [4:0] state;
    reg [3:0] bit_cnt;
    reg [12:0] cmd_sr;
    reg [15:0] data_sr;
    reg [1:0] job;
    reg [10:0] job_addr;
    reg [10:0] rd_addr;
    reg [3:0] rd_bit;
    reg stat_en;
    reg release_pend;
    reg [TIMER_W-1:0] timer;
    reg [10:0] sweep;
    reg sweeping;

    // frame decode; the command register holds bits after the start bit
    wire [3:0] cmd_len = wide ? 4'd12 : 4'd13; // [R1]
    wire [3:0] data_last = wide ? 4'd15 : 4'd7;
    wire [12:0] cmd_now = {cmd_sr[11:0], di};
    wire [1:0] op = wide ? cmd_now[11:10] : cmd_now[12:11]; // [R19]
    wire [1:0] sub = wide ? cmd_now[9:8] : cmd_now[10:9]; // [R19]
    wire [10:0] addr_now = wide ? {1'b0, cmd_now[9:0]} : cmd_now[10:0];
    wire [15:0] data_now = {data_sr[14:0], di};

    // memory ports
    wire [15:0] rdata;
    reg mem_we;
    reg [1:0] mem_be;
    reg [9:0] mem_waddr;
    reg [15:0] mem_wdata;
    wire [9:0] mem_raddr = wide ? rd_addr[9:0] : rd_addr[10:1];

    word_store #(.AW(10), .DW(16)) store (
        .mclk(mclk),
        .we(mem_we),
        .be(mem_be),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(rdata)
    );

    // bit to send: x8 takes a byte lane picked by the low address bit
    wire rd_bit_val = wide ? rdata[rd_bit] :
                      (rd_addr[0] ? rdata[{1'b1, rd_bit[2:0]}] : rdata[{1'b0, rd_bit[2:0]}]);

    // write data path, byte mode duplicates the byte into both lanes
    wire [15:0] job_word = (job == JOB_ERASE || job == JOB_CLEAR) ? `ERASED_WORD :
                           (wide ? data_sr : {data_sr[7:0], data_sr[7:0]}); // [R16]
    wire job_bulk = (job == JOB_FILL) || (job == JOB_CLEAR);

    // instruction decoder, read streaming and status output
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            cmd_sr <= 13'h0000;
            data_sr <= 16'h0000;
            job <= JOB_WRITE;
            job_addr <= 11'h000;
            rd_addr <= 11'h000;
            rd_bit <= 4'h0;
            stat_en <= 1'b0;
            release_pend <= 1'b0;
            write_unlocked <= 1'b0; // [R20]
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else if (!cs) begin
            // deselect ends any frame; unfinished ones change nothing
            state <= ST_IDLE; // [R23]
            bit_cnt <= 4'h0;
            release_pend <= 1'b0;
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0; // [R4]
            if (cs_fall && state == ST_DONE && !program_busy && write_unlocked && pe_sy[1]) begin
                stat_en <= 1'b1; // [R8]
            end
        end else begin
            // status is shown while selected until released by a one
            if (stat_en && state != ST_READ) begin
                serial_out <= ~program_busy; // [R5]
                serial_out_oe <= 1'b1;
            end
            if (sk_fall && release_pend) begin
                stat_en <= 1'b0; // [R6]
                release_pend <= 1'b0;
                serial_out <= 1'b0;
                serial_out_oe <= 1'b0;
            end
            if (sk_rise) begin // [R3]
                case (state)
                    ST_IDLE: begin
                        if (di) begin
                            if (stat_en) begin
                                release_pend <= 1'b1; // [R6]
                            end
                            if (!program_busy) begin
                                state <= ST_CMD; // [R22]
                                bit_cnt <= 4'h0;
                            end
                        end
                    end
                    ST_CMD: begin
                        cmd_sr <= cmd_now; // [R2]
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == cmd_len - 4'h1) begin
                            bit_cnt <= 4'h0;
                            job_addr <= addr_now;
                            state <= ST_DONE;
                            if (op == `OP_READ) begin
                                state <= ST_READ;
                                rd_addr <= addr_now;
                                rd_bit <= data_last;
                                serial_out <= 1'b0; // [R9]
                                serial_out_oe <= 1'b1;
                                stat_en <= 1'b0;
                            end else if (op == `OP_WRITE) begin
                                job <= JOB_WRITE;
                                state <= ST_DATA;
                            end else if (op == `OP_ERASE) begin
                                job <= JOB_ERASE;
                            end else if (sub == `SUB_FILL) begin
                                job <= JOB_FILL;
                                state <= ST_DATA;
                            end else if (sub == `SUB_CLEAR) begin
                                job <= JOB_CLEAR;
                            end else begin
                                // lock and unlock take effect at once, pin ignored
                                write_unlocked <= (sub == `SUB_UNLOCK); // [R8]
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_DATA: begin
                        data_sr <= data_now; // [R2]
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == data_last) begin
                            state <= ST_DONE;
                        end
                    end
                    ST_READ: begin
                        serial_out <= rd_bit_val; // [R10]
                        serial_out_oe <= 1'b1;
                        if (rd_bit == 4'h0) begin
                            // next word follows with no dummy bit
                            rd_bit <= data_last; // [R12]
                            rd_addr <= wide ? {1'b0, rd_addr[9:0] + 10'h001} : rd_addr + 11'h001; // [R11]
                        end else begin
                            rd_bit <= rd_bit - 4'h1; // [R9]
                        end
                    end
                    default: begin
                        // extra clocks after a complete frame are ignored
                        state <= state;
                    end
                endcase
            end
        end
    end

    // self-timed program cycle, runs from mclk only
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            program_busy <= 1'b0;
            timer <= {TIMER_W{1'b0}};
            sweep <= 11'h000;
            sweeping <= 1'b0;
            mem_we <= 1'b0;
            mem_be <= 2'b00;
            mem_waddr <= 10'h000;
            mem_wdata <= 16'h0000;
        end else begin
            mem_we <= 1'b0;
            if (!program_busy) begin
                if (cs_fall && state == ST_DONE && write_unlocked && pe_sy[1]) begin
                    program_busy <= 1'b1; // [R14]
                    timer <= PROG_CYCLES[TIMER_W-1:0]; // [R17]
                    sweep <= 11'h000;
                    sweeping <= job_bulk;
                    // single word: clear and store in one masked write, one lane in x8, both in x16
                    mem_we <= ~job_bulk;
                    mem_wdata <= job_word;
                    mem_waddr <= wide ? job_addr[9:0] : job_addr[10:1];
                    mem_be <= wide ? 2'b11 : (job_addr[0] ? 2'b10 : 2'b01);
                end
            end else begin
                timer <= timer - {{(TIMER_W-1){1'b0}}, 1'b1}; // [R15]
                if (timer == {{(TIMER_W-1){1'b0}}, 1'b1}) begin
                    program_busy <= 1'b0; // [R17]
                end
                // bulk jobs walk every word, well inside the cycle time
                if (sweeping) begin
                    mem_we <= 1'b1;
                    mem_be <= 2'b11;
                    mem_waddr <= sweep[9:0];
                    mem_wdata <= job_word;
                    sweep <= sweep + 11'h001;
                    if (sweep[9:0] == 10'h3ff) begin
                        sweeping <= 1'b0;
                    end
                end
            end
        end
    end

endmodule // serial_eeprom

`default_nettype wire

/* File: rtl/eeprom_regs.vh */
`ifndef EEPROM_REGS_VH
`define EEPROM_REGS_VH

// frame lengths in bits, start bit included, write data excluded
`define FRAME_LEN_X16 13
`define FRAME_LEN_X8 14
// address and data widths per organisation
`define ADDR_LEN_X16 10
`define ADDR_LEN_X8 11
`define DATA_LEN_X16 16
`define DATA_LEN_X8 8
// opcode field values
`define OP_SPECIAL 2'b00
`define OP_WRITE 2'b01
`define OP_READ 2'b10
`define OP_ERASE 2'b11
// special group selector (two leading address bits)
`define SUB_LOCK 2'b00
`define SUB_FILL 2'b01
`define SUB_CLEAR 2'b10
`define SUB_UNLOCK 2'b11
// timing
`define MCLK_HZ 100000000
`define PROGRAM_CYCLE_TIME_MS 5
`define POWERUP_READ_DELAY_MS 1
`define POWERUP_WRITE_DELAY_MS 1
// erased word value
`define ERASED_WORD 16'hffff

`endif

/* File: rtl/word_store.v */
`timescale 1ns/10ps
`default_nettype none

module word_store #(
    parameter AW = 10,
    parameter DW = 16
) (
    input wire mclk,
    input wire we,
    input wire [DW/8-1:0] be,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // one write lane per byte, so x8 writes leave the other byte alone
    genvar i;
    generate
        for (i = 0; i < DW/8; i = i + 1) begin : lane
            always @(posedge mclk) begin
                if (we && be[i]) begin
                    mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
                end
            end
        end
    endgenerate

    // registered read port
    always @(posedge mclk) begin
        rdata <= mem[raddr];
    end

endmodule // word_store

`default_nettype wire

/* File: tb/eeprom_host.sv */
`timescale 1ns/10ps
`default_nettype none
module eeprom_host (
    output logic cs,
    output logic sk,
    output logic di,
    input wire logic dout
);
    logic [31:0] rx;
    // clock stands low and the host is deselected between frames
    initial begin
        cs = 1'b0;
        sk = 1'b0;
        di = 1'b0;
        rx = 32'h0;
    end
    // msb first, data set half a period before the rise
    task automatic shift(input logic [31:0] val, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            di = val[i];
            #62 sk = 1'b1;
            #63 sk = 1'b0;
            rx = {rx[30:0], dout};
        end
    endtask
    task automatic open_frame();
        cs = 1'b1;
        #200;
    endtask
    // deselect leaves the data input at the inverse of its last level
    task automatic close_frame();
        cs = 1'b0;
        di = ~di;
        #1000;
    endtask
    task automatic frame(input logic [31:0] val, input int n);
        open_frame();
        shift(val, n);
        close_frame();
    endtask
endmodule // eeprom_host
`default_nettype wire

/* File: tb/serial_eeprom_props.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_props #(
    parameter int PROG_CYCLES = 2000
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic width_select,
    input wire logic program_enable,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic program_busy,
    input wire logic write_unlocked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic sk_q;
    int sk_age;
    int busy_age;
    int busy_cnt;
    // ages saturate so long idle spans never wrap
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sk_q <= 1'b0;
            sk_age <= 99;
            busy_age <= 99;
            busy_cnt <= 0;
        end else begin
            sk_q <= serial_clock;
            sk_age <= (serial_clock && !sk_q) ? 0 : (sk_age < 99 ? sk_age + 1 : 99);
            busy_age <= program_busy ? 0 : (busy_age < 99 ? busy_age + 1 : 99);
            busy_cnt <= program_busy ? busy_cnt + 1 : 0;
        end
    end
    a_oe_needs_select: assert property (!chip_select [*5] |-> !serial_out_oe) else $error("oe while deselected");
    a_busy_after_drop: assert property ($rose(program_busy) |-> !chip_select) else $error("busy while selected");
    a_busy_unlocked: assert property ($rose(program_busy) |-> write_unlocked) else $error("busy while locked");
    a_busy_enabled: assert property ($rose(program_busy) |-> $past(program_enable, 4)) else $error("busy, pe low");
    a_cycle_bounded: assert property (busy_cnt <= PROG_CYCLES + 2) else $error("cycle too long");
    a_busy_self_clocked: assert property ($rose(program_busy) |=> program_busy [*8]) else $error("busy cut");
    a_status_low: assert property (chip_select && serial_out_oe && program_busy |-> !serial_out)
        else $error("status high while busy");
    a_out_on_rise: assert property ($changed(serial_out) && serial_out_oe && $past(serial_out_oe) && busy_age > 8
        |-> sk_age <= 6) else $error("out moved off clock");
    a_lock_in_frame: assert property ($changed(write_unlocked) |-> chip_select) else $error("lock off frame");
    // main scenarios
    cover property ($rose(program_busy));
    cover property ($fell(serial_out_oe) && chip_select);
    cover property ($rose(write_unlocked));
endmodule // serial_eeprom_props
bind serial_eeprom serial_eeprom_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (.mclk(mclk), .arst_n(arst_n),
    .chip_select(chip_select), .serial_clock(serial_clock), .serial_in(serial_in), .width_select(width_select),
    .program_enable(program_enable), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .program_busy(program_busy), .write_unlocked(write_unlocked));
`default_nettype wire

/* File: tb/tb_serial_eeprom.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_serial_eeprom;
    localparam int PROG = 2000;
    logic mclk, arst_n, wsel, pe;
    wire cs, sk, di, so, so_oe, busy, unl;
    // released line floats so a stray sample cannot match
    wire line = so_oe ? so : 1'bz;
    int mismatches, cmp_count, cycles;
    eeprom_host i_host (.cs(cs), .sk(sk), .di(di), .dout(line));
    serial_eeprom #(.PROG_CYCLES(PROG)) i_dut (.mclk(mclk), .arst_n(arst_n), .chip_select(cs),
        .serial_clock(sk), .serial_in(di), .width_select(wsel), .program_enable(pe), .serial_out(so),
        .serial_out_oe(so_oe), .program_busy(busy), .write_unlocked(unl));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, well above the whole sequence
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < PROG + 500) begin
            @(posedge mclk);
            k++;
        end
        chk("busy", v, busy);
    endtask
    task automatic t_locked();
        chk("unlocked", 0, unl);
        i_host.frame({3'b101, 10'h3ff, 16'ha5c3}, 29);
        chk("busy", 0, busy);
        i_host.frame({3'b100, 2'b11, 8'h00}, 13);
        chk("unlocked", 1, unl);
        $display("done locked");
    endtask
    task automatic t_write();
        i_host.frame({3'b101, 10'h3ff, 16'ha5c3}, 29);
        wait_busy(1);
        i_host.open_frame();
        chk("status oe", 1, so_oe);
        chk("status", 0, so);
        wait_busy(0);
        #100 chk("status", 1, so);
        i_host.shift(1, 1);
        #100 chk("oe", 0, so_oe);
        i_host.close_frame();
        i_host.frame({3'b111, 10'h000}, 13);
        wait_busy(1);
        wait_busy(0);
        pe = 1'b0;
        i_host.frame({3'b111, 10'h3ff}, 13);
        chk("busy", 0, busy);
        pe = 1'b1;
        $display("done write");
    endtask
    task automatic t_read();
        i_host.open_frame();
        i_host.shift({3'b000, 3'b110, 10'h3ff}, 16);
        chk("dummy", 0, i_host.rx[0]);
        i_host.shift(0, 32);
        chk("word", 16'ha5c3, i_host.rx[31:16]);
        chk("wrapped", 16'hffff, i_host.rx[15:0]);
        i_host.close_frame();
        chk("oe", 0, so_oe);
        wsel = 1'b0;
        i_host.open_frame();
        i_host.shift({3'b110, 11'h7ff}, 14);
        chk("dummy", 0, i_host.rx[0]);
        i_host.shift(0, 16);
        chk("bytes", 16'ha5ff, i_host.rx[15:0]);
        i_host.close_frame();
        wsel = 1'b1;
        $display("done read");
    endtask
    task automatic t_abort();
        i_host.frame({3'b111, 5'h00}, 8);
        chk("busy", 0, busy);
        i_host.frame({3'b100, 10'h000}, 13);
        chk("unlocked", 0, unl);
        $display("done abort");
    endtask
    initial begin
        arst_n = 1'b0;
        wsel = 1'b1;
        pe = 1'b1;
        repeat (20) @(posedge mclk);
        #1 arst_n = 1'b1;
        repeat (100) @(posedge mclk);
        t_locked();
        t_write();
        t_read();
        t_abort();
        print_verdict();
    end
endmodule // tb_serial_eeprom
`default_nettype wire
